/* File: verilog/pqu_pkg.sv */
// Shared types and constants of the product/quotient unit.
package pqu_pkg;

    // Operations handed over at the end of the execute stage
    typedef enum logic [3:0] {
        OP_NONE                        = 4'h0,
        OP_PRODUCT_TO_REGISTER_FILE    = 4'h1,
        OP_SIGNED_PRODUCT_TO_PAIR      = 4'h2,
        OP_UNSIGNED_PRODUCT_TO_PAIR    = 4'h3,
        OP_SIGNED_PRODUCT_ACCUMULATE   = 4'h4,
        OP_UNSIGNED_PRODUCT_ACCUMULATE = 4'h5,
        OP_SIGNED_PRODUCT_DEDUCT       = 4'h6,
        OP_UNSIGNED_PRODUCT_DEDUCT     = 4'h7,
        OP_SIGNED_QUOTIENT             = 4'h8,
        OP_UNSIGNED_QUOTIENT           = 4'h9,
        OP_MOVE_FROM_UPPER_RESULT      = 4'ha,
        OP_MOVE_FROM_BOTTOM_RESULT     = 4'hb,
        OP_MOVE_TO_UPPER_RESULT        = 4'hc,
        OP_MOVE_TO_BOTTOM_RESULT       = 4'hd
    } pqu_op_e;

    // Divider sequencer states
    typedef enum logic [2:0] {
        DIV_IDLE   = 3'b000,
        DIV_ADJUST = 3'b001,
        DIV_ITER   = 3'b010,
        DIV_REM    = 3'b011,
        DIV_SIGN   = 3'b100
    } pqu_div_e;

    // Issue request from the integer unit
    typedef struct packed {
        logic        valid;
        pqu_op_e     op;
        logic [31:0] src_a;
        logic [31:0] src_b;
        logic [4:0]  dest;
        logic        next_uses;  // Following integer op reads the result
    } pqu_issue_s;

    // Register file write toward the integer unit
    typedef struct packed {
        logic        en;
        logic [4:0]  addr;
        logic [31:0] data;
    } pqu_gpr_wr_s;

    // Divide iteration counts after early detection
    localparam logic [5:0] DIV_ITERS_8  = 6'h08;
    localparam logic [5:0] DIV_ITERS_16 = 6'h10;
    localparam logic [5:0] DIV_ITERS_24 = 6'h18;
    localparam logic [5:0] DIV_ITERS_32 = 6'h20;

    // Issue blocking and integer hold figures, in clocks
    localparam logic [5:0] WIDE_MULT_BLOCK = 6'h01;
    localparam logic [1:0] TGT_HOLD_NARROW = 2'h1;
    localparam logic [1:0] TGT_HOLD_WIDE   = 2'h2;
    localparam logic [1:0] TGT_HOLD_DEP    = 2'h1;

    // Reset values
    localparam logic [31:0] PAIR_RESET = 32'h0000_0000;

endpackage : pqu_pkg

/* File: verilog/pqu_core.sv */
// Product/quotient unit running beside the integer pipeline.
//
// Function
// - Targeted multiply writes its low product to any general register.
// - Accumulate adds product to the pair; deduct subtracts it.
// - Other multiplies write the pair; integer ops never wait on them.
// - Move from pair waits until pending result data is available.
// - Unit pipeline advances regardless of integer pipeline stalls.
// - 32x16 array; second operand width alone picks one or two passes.
// - Narrow multiply accepted each clock, wide one every second clock.
// - Divide yields one quotient bit per clock, early width detect.
// - Any unit op offered during a divide is held until the divide's last two clocks.
// - Multiply to dependent op latency: one clock narrow, two wide.
// - Unsigned divide latency 9, 17, 25 or 33 by dividend width.
// - Signed divide one clock longer unless both operands positive.
// - Dependent op back to back costs one extra stall at latency one or two.
// - Targeted multiply holds integer pipe one (narrow) or two clocks.
// - One extra hold when the next integer op uses that result.
// - Work starts at end of execute; stages align with memory/align/wb.
// - Narrow multiply one clock per stage; wide takes array twice.
// - Multi-pass ops may skew against integer pipe harmlessly.
// - Completed non-targeted multiply updates the result pair in unit writeback.
// - Unit ops are taken over at the end of the execute stage.
// - Zero upper 8, 16 or 24 dividend bits skip 8, 16 or 24 steps.
`timescale 1ns/1ps
`default_nettype none

module pqu_core (
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               reset_n_in,
    // Issue from the integer unit
    input  wire pqu_pkg::pqu_issue_s issue_in,
    // Stall toward the integer unit
    output var  logic               issue_block_out,
    output var  logic               iu_hold_out,
    output var  logic               div_busy_out,
    // Register file write and pair contents
    output var  pqu_pkg::pqu_gpr_wr_s gpr_wr_out,
    output var  logic [31:0]        upper_result_out,
    output var  logic [31:0]        bottom_result_out
);

    // Operand classification helpers
    function automatic logic fits16(input logic [31:0] b, input logic sgn);
        fits16 = sgn ? (b[31:15] == {17{b[15]}}) : (b[31:16] == 16'h0000);
    endfunction : fits16

    function automatic logic is_signed(input pqu_pkg::pqu_op_e op);
        is_signed = (op == pqu_pkg::OP_PRODUCT_TO_REGISTER_FILE) ||
                    (op == pqu_pkg::OP_SIGNED_PRODUCT_TO_PAIR) ||
                    (op == pqu_pkg::OP_SIGNED_PRODUCT_ACCUMULATE) ||
                    (op == pqu_pkg::OP_SIGNED_PRODUCT_DEDUCT) ||
                    (op == pqu_pkg::OP_SIGNED_QUOTIENT);
    endfunction : is_signed

    function automatic logic is_mult(input pqu_pkg::pqu_op_e op);
        is_mult = (op >= pqu_pkg::OP_PRODUCT_TO_REGISTER_FILE) &&
                  (op <= pqu_pkg::OP_UNSIGNED_PRODUCT_DEDUCT);
    endfunction : is_mult

    function automatic logic [31:0] magnitude(input logic [31:0] v,
                                              input logic neg);
        magnitude = neg ? (32'h0000_0000 - v) : v;
    endfunction : magnitude

    // Iterations left after checking zero upper dividend bytes
    function automatic logic [5:0] div_iters(input logic [31:0] mag);
        if (mag[31:8] == 24'h00_0000) begin
            div_iters = pqu_pkg::DIV_ITERS_8;
        end else if (mag[31:16] == 16'h0000) begin
            div_iters = pqu_pkg::DIV_ITERS_16;
        end else if (mag[31:24] == 8'h00) begin
            div_iters = pqu_pkg::DIV_ITERS_24;
        end else begin
            div_iters = pqu_pkg::DIV_ITERS_32;
        end
    endfunction : div_iters

    // Issue decode
    logic        accept;
    logic        acc_sgn;
    logic        acc_mult;
    logic        acc_wide;
    logic        acc_div;
    logic        acc_neg_a;
    logic        sign_step;
    logic [5:0]  acc_iters;
    logic [5:0]  blk_cnt_r;
    logic [5:0]  blk_cnt_nxt;
    logic [1:0]  hold_cnt_r;
    logic [1:0]  hold_cnt_nxt;

    assign accept    = issue_in.valid && !issue_block_out;
    assign acc_sgn   = is_signed(issue_in.op);
    assign acc_mult  = is_mult(issue_in.op);
    // Pass count from second operand only
    assign acc_wide  = !fits16(issue_in.src_b, acc_sgn);
    assign acc_div   = (issue_in.op == pqu_pkg::OP_SIGNED_QUOTIENT) ||
                       (issue_in.op == pqu_pkg::OP_UNSIGNED_QUOTIENT);
    assign acc_neg_a = acc_sgn && issue_in.src_a[31];
    // Sign step skipped when both positive
    assign sign_step = acc_sgn && (issue_in.src_a[31] || issue_in.src_b[31]);
    assign acc_iters = div_iters(magnitude(issue_in.src_a, acc_neg_a));

    // Issue block counter; block is a flop so it sees no issue path
    always_comb begin
        blk_cnt_nxt = (blk_cnt_r != 6'h00) ? blk_cnt_r - 6'h01 : 6'h00;
        if (accept && acc_mult && acc_wide) begin
            blk_cnt_nxt = pqu_pkg::WIDE_MULT_BLOCK;
        end else if (accept && acc_div) begin
            blk_cnt_nxt = acc_iters + {5'h00, sign_step};
        end
    end

    // Block all unit issue until the last two divide clocks
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            blk_cnt_r       <= 6'h00;
            issue_block_out <= 1'b0;
        end else begin
            blk_cnt_r       <= blk_cnt_nxt;
            issue_block_out <= (blk_cnt_nxt != 6'h00);
        end
    end

    // Integer hold for the targeted multiply write slot
    always_comb begin
        hold_cnt_nxt = (hold_cnt_r != 2'h0) ? hold_cnt_r - 2'h1 : 2'h0;
        if (accept &&
            issue_in.op == pqu_pkg::OP_PRODUCT_TO_REGISTER_FILE) begin
            hold_cnt_nxt = acc_wide ? pqu_pkg::TGT_HOLD_WIDE
                                    : pqu_pkg::TGT_HOLD_NARROW;
            if (issue_in.next_uses) begin
                hold_cnt_nxt = hold_cnt_nxt + pqu_pkg::TGT_HOLD_DEP;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            hold_cnt_r  <= 2'h0;
            iu_hold_out <= 1'b0;
        end else begin
            hold_cnt_r  <= hold_cnt_nxt;
            iu_hold_out <= (hold_cnt_nxt != 2'h0);
        end
    end

    // Array stage registers
    logic              m_valid_r;
    pqu_pkg::pqu_op_e  m_op_r;
    logic [31:0]       m_a_r;
    logic [31:0]       m_b_r;
    logic [4:0]        m_dest_r;
    logic              m_sgn_r;
    logic              m_wide_r;
    logic              m_pass2_r;
    logic [63:0]       m_acc_r;
    logic signed [32:0] a_ext;
    logic signed [16:0] b_sel;
    logic signed [49:0] part;
    logic [63:0]       part_ext;
    logic [63:0]       m_prod;
    logic              m_done;

    assign a_ext    = signed'({m_sgn_r & m_a_r[31], m_a_r});
    assign b_sel    = !m_wide_r ? signed'({m_sgn_r & m_b_r[15], m_b_r[15:0]})
                    : !m_pass2_r ? signed'({1'b0, m_b_r[15:0]})
                    : signed'({m_sgn_r & m_b_r[31], m_b_r[31:16]});
    assign part     = a_ext * b_sel;
    assign part_ext = {{14{part[49]}}, part};
    assign m_prod   = m_pass2_r ? m_acc_r + {part_ext[47:0], 16'h0000}
                                : part_ext;
    // Wide op stays a second clock
    assign m_done   = m_valid_r && (!m_wide_r || m_pass2_r);

    // Unit stages never look at integer stalls
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            m_valid_r <= 1'b0;
            m_pass2_r <= 1'b0;
        end else if (m_valid_r && m_wide_r && !m_pass2_r) begin
            m_pass2_r <= 1'b1;
        end else begin
            m_valid_r <= accept && !acc_div;
            m_pass2_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (m_valid_r && m_wide_r && !m_pass2_r) begin
            m_acc_r <= part_ext;
        end else if (accept) begin
            m_op_r   <= issue_in.op;
            m_a_r    <= issue_in.src_a;
            m_b_r    <= issue_in.src_b;
            m_dest_r <= issue_in.dest;
            m_sgn_r  <= acc_sgn;
            m_wide_r <= acc_mult && acc_wide;
        end
    end

    // Accumulate stage registers
    logic              a_valid_r;
    pqu_pkg::pqu_op_e  a_op_r;
    logic [31:0]       a_src_r;
    logic [4:0]        a_dest_r;
    logic [63:0]       a_prod_r;
    logic [63:0]       pair;

    // Bubble after a first pass is harmless
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            a_valid_r <= 1'b0;
        end else begin
            a_valid_r <= m_done;
        end
    end

    always_ff @(posedge clk_in) begin
        if (m_done) begin
            a_op_r   <= m_op_r;
            a_src_r  <= m_a_r;
            a_dest_r <= m_dest_r;
            a_prod_r <= m_prod;
        end
    end

    assign pair = {upper_result_out, bottom_result_out};

    // Divider state
    pqu_pkg::pqu_div_e dv_state_r;
    logic [31:0]       dv_a_r;
    logic [31:0]       dv_b_r;
    logic              dv_neg_a_r;
    logic              dv_neg_b_r;
    logic              dv_sign_r;
    logic [5:0]        dv_iters_r;
    logic [5:0]        dv_left_r;
    logic [31:0]       dv_d_r;
    logic [32:0]       dv_rem_r;
    logic [31:0]       dv_quo_r;
    logic [32:0]       dv_trial;
    logic              dv_write;

    assign dv_trial = {dv_rem_r[31:0], dv_quo_r[31]} - {1'b0, dv_d_r};
    assign dv_write = (dv_state_r == pqu_pkg::DIV_SIGN) ||
                      (dv_state_r == pqu_pkg::DIV_REM && !dv_sign_r);

    // Restoring divide, one bit per clock
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            dv_state_r <= pqu_pkg::DIV_IDLE;
        end else begin
            case (dv_state_r)
                pqu_pkg::DIV_IDLE: begin
                    if (accept && acc_div) begin
                        dv_state_r <= pqu_pkg::DIV_ADJUST;
                    end
                end
                pqu_pkg::DIV_ADJUST: begin
                    dv_state_r <= pqu_pkg::DIV_ITER;
                end
                pqu_pkg::DIV_ITER: begin
                    if (dv_left_r == 6'h01) begin
                        dv_state_r <= pqu_pkg::DIV_REM;
                    end
                end
                pqu_pkg::DIV_REM: begin
                    dv_state_r <= dv_sign_r ? pqu_pkg::DIV_SIGN
                                            : pqu_pkg::DIV_IDLE;
                end
                default: begin
                    dv_state_r <= pqu_pkg::DIV_IDLE;
                end
            endcase
        end
    end

    // Divider datapath; operand negation happens in the adjust clock
    always_ff @(posedge clk_in) begin
        if (dv_state_r == pqu_pkg::DIV_IDLE && accept && acc_div) begin
            dv_a_r     <= issue_in.src_a;
            dv_b_r     <= issue_in.src_b;
            dv_neg_a_r <= acc_neg_a;
            dv_neg_b_r <= acc_sgn && issue_in.src_b[31];
            dv_sign_r  <= sign_step;
            dv_iters_r <= acc_iters;
        end else if (dv_state_r == pqu_pkg::DIV_ADJUST) begin
            dv_d_r    <= magnitude(dv_b_r, dv_neg_b_r);
            dv_rem_r  <= 33'h0_0000_0000;
            dv_quo_r  <= magnitude(dv_a_r, dv_neg_a_r)
                         << (pqu_pkg::DIV_ITERS_32 - dv_iters_r);
            dv_left_r <= dv_iters_r;
        end else if (dv_state_r == pqu_pkg::DIV_ITER) begin
            dv_left_r <= dv_left_r - 6'h01;
            if (!dv_trial[32]) begin
                dv_rem_r <= dv_trial;
                dv_quo_r <= {dv_quo_r[30:0], 1'b1};
            end else begin
                dv_rem_r <= {dv_rem_r[31:0], dv_quo_r[31]};
                dv_quo_r <= {dv_quo_r[30:0], 1'b0};
            end
        end else if (dv_state_r == pqu_pkg::DIV_SIGN) begin
            dv_quo_r <= magnitude(dv_quo_r, dv_neg_a_r ^ dv_neg_b_r);
            dv_rem_r <= {1'b0, magnitude(dv_rem_r[31:0], dv_neg_a_r)};
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            div_busy_out <= 1'b0;
        end else begin
            div_busy_out <= (dv_state_r != pqu_pkg::DIV_IDLE || acc_div &&
                             accept) && !(dv_write &&
                             dv_state_r != pqu_pkg::DIV_REM);
        end
    end

    // Result pair; divide and multiply writes never meet by issue blocking
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            upper_result_out  <= pqu_pkg::PAIR_RESET;
            bottom_result_out <= pqu_pkg::PAIR_RESET;
        end else if (dv_write) begin
            upper_result_out  <= (dv_state_r == pqu_pkg::DIV_SIGN) ?
                                 magnitude(dv_rem_r[31:0], dv_neg_a_r) :
                                 dv_rem_r[31:0];
            bottom_result_out <= (dv_state_r == pqu_pkg::DIV_SIGN) ?
                                 magnitude(dv_quo_r, dv_neg_a_r ^ dv_neg_b_r) :
                                 dv_quo_r;
        end else if (a_valid_r) begin
            case (a_op_r)
                pqu_pkg::OP_SIGNED_PRODUCT_ACCUMULATE,
                pqu_pkg::OP_UNSIGNED_PRODUCT_ACCUMULATE: begin
                    {upper_result_out, bottom_result_out} <= pair + a_prod_r;
                end
                pqu_pkg::OP_SIGNED_PRODUCT_DEDUCT,
                pqu_pkg::OP_UNSIGNED_PRODUCT_DEDUCT: begin
                    {upper_result_out, bottom_result_out} <= pair - a_prod_r;
                end
                // Plain multiplies land in the pair
                pqu_pkg::OP_SIGNED_PRODUCT_TO_PAIR,
                pqu_pkg::OP_UNSIGNED_PRODUCT_TO_PAIR: begin
                    {upper_result_out, bottom_result_out} <= a_prod_r;
                end
                pqu_pkg::OP_MOVE_TO_UPPER_RESULT: begin
                    upper_result_out <= a_src_r;
                end
                pqu_pkg::OP_MOVE_TO_BOTTOM_RESULT: begin
                    bottom_result_out <= a_src_r;
                end
                default: begin
                    upper_result_out <= upper_result_out;
                end
            endcase
        end
    end

    // Register file write in unit writeback
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            gpr_wr_out <= '0;
        end else begin
            gpr_wr_out.addr <= a_dest_r;
            // Moves read pair in order, after older writes
            gpr_wr_out.en   <= a_valid_r &&
                (a_op_r == pqu_pkg::OP_PRODUCT_TO_REGISTER_FILE ||
                 a_op_r == pqu_pkg::OP_MOVE_FROM_UPPER_RESULT ||
                 a_op_r == pqu_pkg::OP_MOVE_FROM_BOTTOM_RESULT);
            gpr_wr_out.data <=
                (a_op_r == pqu_pkg::OP_MOVE_FROM_UPPER_RESULT) ?
                upper_result_out :
                (a_op_r == pqu_pkg::OP_MOVE_FROM_BOTTOM_RESULT) ?
                bottom_result_out : a_prod_r[31:0];
        end
    end

    // Checks on stall timing and stage flow
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    logic tgt;
    logic div_small;
    assign tgt = accept && issue_in.op == pqu_pkg::OP_PRODUCT_TO_REGISTER_FILE;
    assign div_small = accept && acc_div && acc_iters == pqu_pkg::DIV_ITERS_8;

    property p_wide_block;
        accept && acc_mult && acc_wide
            |=> issue_block_out ##1 !issue_block_out;
    endproperty
    a_wide_block: assert property (p_wide_block)
        else $error("wide multiply block not one clock");

    property p_narrow_flow;
        accept && acc_mult && !acc_wide |-> ##1 !issue_block_out ##1 a_valid_r;
    endproperty
    a_narrow_flow: assert property (p_narrow_flow)
        else $error("narrow multiply not in accumulate after two clocks");

    property p_wide_flow;
        accept && acc_mult && acc_wide |-> ##2 !a_valid_r ##1 a_valid_r;
    endproperty
    a_wide_flow: assert property (p_wide_flow)
        else $error("wide multiply not two clocks in array");

    property p_tgt_hold;
        tgt && !acc_wide && !issue_in.next_uses
            |=> iu_hold_out ##1 !iu_hold_out;
    endproperty
    a_tgt_hold: assert property (p_tgt_hold)
        else $error("narrow targeted multiply hold not one clock");

    property p_tgt_dep;
        tgt && acc_wide && issue_in.next_uses
            |=> iu_hold_out[*3] ##1 !iu_hold_out;
    endproperty
    a_tgt_dep: assert property (p_tgt_dep)
        else $error("dependent wide targeted hold not three clocks");

    property p_tgt_write;
        tgt && !acc_wide |-> ##3 gpr_wr_out.en &&
            gpr_wr_out.addr == $past(issue_in.dest, 3);
    endproperty
    a_tgt_write: assert property (p_tgt_write)
        else $error("targeted product not written to register file");

    property p_udiv8;
        div_small && !sign_step |=> issue_block_out[*8] ##1 !issue_block_out;
    endproperty
    a_udiv8: assert property (p_udiv8)
        else $error("short unsigned divide latency not nine");

    property p_sdiv8;
        div_small && sign_step
            |=> issue_block_out[*8] ##1 issue_block_out ##1 !issue_block_out;
    endproperty
    a_sdiv8: assert property (p_sdiv8)
        else $error("short signed divide latency not ten");

    property p_reset_clear;
        disable iff (1'b0)
        !reset_n_in |=> !issue_block_out && !iu_hold_out && !div_busy_out;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("stall outputs not cleared by reset");

endmodule : pqu_core

`default_nettype wire

/* File: tb/pqu_iu_model.sv */
// Integer unit model: offers unit ops and holds each until taken.
`timescale 1ns/1ps
`default_nettype none
module pqu_iu_model (
    // Clock and stall from the unit
    input  wire logic                clk_in,
    input  wire logic                block_in,
    // Issue toward the unit
    output var  pqu_pkg::pqu_issue_s issue_out
);
    initial issue_out = '0;
    // Offer one op; k counts edges up to the taking edge
    task automatic issue(input pqu_pkg::pqu_op_e op, input logic [31:0] a,
                         input logic [31:0] b, input logic nu, output int k);
        issue_out = {1'b1, op, a, b, 5'h13, nu};
        k = 1;
        // Held whole while refused, never withdrawn early
        while (block_in === 1'b1) begin
            @(posedge clk_in);
            #1;
            k++;
        end
        @(posedge clk_in);
        #1;
    endtask : issue
    // Withdraw; kept apart so back-to-back offers never double-assign
    task automatic idle();
        issue_out = '0;
    endtask : idle
endmodule : pqu_iu_model
`default_nettype wire

/* File: tb/multiply_divide_pipeline_tb_top.sv */
// Self-checking bench for the product/quotient unit.
`timescale 1ns/1ps
`default_nettype none
module multiply_divide_pipeline_tb_top;
    logic                 clk_in;
    logic                 reset_n_in;
    logic                 blk;
    logic                 hold;
    logic                 busy;
    logic [31:0]          up;
    logic [31:0]          bot;
    pqu_pkg::pqu_issue_s  iss;
    pqu_pkg::pqu_gpr_wr_s wr;
    int                   failures = 0;
    int                   samples_checked = 0;
    int                   cyc = 0;
    int                   k;

    pqu_core dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .issue_in(iss),
        .issue_block_out(blk), .iu_hold_out(hold), .div_busy_out(busy),
        .gpr_wr_out(wr), .upper_result_out(up), .bottom_result_out(bot));
    pqu_iu_model iu (.clk_in(clk_in), .block_in(blk), .issue_out(iss));

    // Clock, 10 ns period
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Hang guard, well above the longest sequence
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick

    task automatic t_narrow();
        iu.issue(pqu_pkg::OP_UNSIGNED_PRODUCT_TO_PAIR, 32'h5, 32'h7, 1'b0, k);
        iu.issue(pqu_pkg::OP_UNSIGNED_PRODUCT_ACCUMULATE, 32'h3, 32'h4,
                 1'b0, k);
        check(32'(k), 32'h1);
        iu.issue(pqu_pkg::OP_SIGNED_PRODUCT_DEDUCT, 32'h2, 32'h3, 1'b0, k);
        iu.issue(pqu_pkg::OP_UNSIGNED_PRODUCT_DEDUCT, 32'h1, 32'h1, 1'b0, k);
        check(32'(k), 32'h1);
        check({31'h0, hold}, 32'h0);
        iu.idle();
        tick(1);
        check(bot, 32'h29);
        tick(1);
        check(bot, 32'h28);
        iu.issue(pqu_pkg::OP_SIGNED_PRODUCT_TO_PAIR, 32'hffff_fffe, 32'h3,
                 1'b0, k);
        iu.issue(pqu_pkg::OP_SIGNED_PRODUCT_ACCUMULATE, 32'h1, 32'h2, 1'b0, k);
        iu.idle();
        tick(2);
        check(up, 32'hffff_ffff);
        check(bot, 32'hffff_fffc);
        $display("narrow done");
    endtask : t_narrow

    task automatic t_wide();
        iu.issue(pqu_pkg::OP_UNSIGNED_PRODUCT_TO_PAIR, 32'h3_0000,
                 32'h1_0000, 1'b0, k);
        iu.issue(pqu_pkg::OP_UNSIGNED_PRODUCT_ACCUMULATE, 32'h1, 32'h1_0000,
                 1'b0, k);
        check(32'(k), 32'h2);
        iu.idle();
        tick(1);
        check(up, 32'h3);
        check(bot, 32'h0);
        tick(2);
        check(bot, 32'h1_0000);
        $display("wide done");
    endtask : t_wide

    // Moves in, carry across the pair, move out in order
    task automatic t_move();
        iu.issue(pqu_pkg::OP_MOVE_TO_UPPER_RESULT, 32'h1, 32'h0, 1'b0, k);
        iu.issue(pqu_pkg::OP_MOVE_TO_BOTTOM_RESULT, 32'h2, 32'h0, 1'b0, k);
        iu.issue(pqu_pkg::OP_UNSIGNED_PRODUCT_ACCUMULATE, 32'hffff_ffff,
                 32'h2, 1'b0, k);
        iu.issue(pqu_pkg::OP_MOVE_FROM_UPPER_RESULT, 32'h0, 32'h0, 1'b0, k);
        iu.idle();
        tick(2);
        check({31'h0, wr.en}, 32'h1);
        check(wr.data, 32'h3);
        check(bot, 32'h0);
        $display("move done");
    endtask : t_move

    task automatic t_target(input logic nu, input logic [31:0] b,
                            input int h, input int g);
        int n;
        int at;
        n = 0;
        at = 0;
        iu.issue(pqu_pkg::OP_PRODUCT_TO_REGISTER_FILE, 32'h6, b, nu, k);
        iu.idle();
        for (int i = 0; i < 5; i++) begin
            if (hold === 1'b1) n++;
            if (wr.en === 1'b1) begin
                at = i;
                check(wr.data, 32'h6 * b);
                check({27'h0, wr.addr}, 32'h13);
            end
            tick(1);
        end
        check(32'(n), 32'(h));
        check(32'(at), 32'(g));
        $display("targeted done");
    endtask : t_target

    task automatic t_div(input pqu_pkg::pqu_op_e op, input logic [31:0] a,
                         input logic [31:0] b, input int l,
                         input logic [31:0] q, input logic [31:0] r);
        iu.issue(op, a, b, 1'b0, k);
        check({31'h0, busy}, 32'h1);
        iu.issue(pqu_pkg::OP_MOVE_FROM_BOTTOM_RESULT, 32'h0, 32'h0, 1'b0, k);
        iu.idle();
        check(32'(k), 32'(l));
        tick(2);
        check({31'h0, wr.en}, 32'h1);
        check(wr.data, q);
        check(up, r);
        check({31'h0, busy}, 32'h0);
        $display("divide done");
    endtask : t_div

    // Reset mid-divide, then a first op right after release
    task automatic t_abort();
        iu.issue(pqu_pkg::OP_UNSIGNED_QUOTIENT, 32'h8000_0000, 32'h3, 1'b0, k);
        iu.idle();
        tick(3);
        check({30'h0, blk, busy}, 32'h3);
        reset_n_in = 1'b0;
        tick(1);
        check({28'h0, blk, hold, busy, wr.en}, 32'h0);
        check(bot | up, 32'h0);
        reset_n_in = 1'b1;
        iu.issue(pqu_pkg::OP_UNSIGNED_PRODUCT_TO_PAIR, 32'h2, 32'h3, 1'b0, k);
        iu.idle();
        tick(2);
        check(bot, 32'h6);
        $display("abort done");
    endtask : t_abort

    task automatic finish_test();
        $display("failures %0d checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    initial begin
        reset_n_in = 1'b0;
        tick(4);
        reset_n_in = 1'b1;
        t_narrow();
        t_wide();
        t_move();
        t_target(1'b0, 32'h3, 1, 2);
        t_target(1'b1, 32'h3, 2, 2);
        t_target(1'b1, 32'h1_0000, 3, 3);
        t_div(pqu_pkg::OP_UNSIGNED_QUOTIENT, 32'h64, 32'h7, 9, 32'he, 32'h2);
        t_div(pqu_pkg::OP_SIGNED_QUOTIENT, 32'hffff_ff9c, 32'h7, 10,
              32'hffff_fff2, 32'hffff_fffe);
        t_div(pqu_pkg::OP_SIGNED_QUOTIENT, 32'h3e8, 32'h7, 17, 32'h8e,
              32'h6);
        t_div(pqu_pkg::OP_UNSIGNED_QUOTIENT, 32'h1_86a0, 32'h7, 25,
              32'h37cd, 32'h5);
        t_div(pqu_pkg::OP_UNSIGNED_QUOTIENT, 32'h8000_0000, 32'h3, 33,
              32'h2aaa_aaaa, 32'h2);
        t_abort();
        finish_test();
    end
endmodule : multiply_divide_pipeline_tb_top
`default_nettype wire
